// ### dwpr_pkg.sv
// shared constants and types for the command-level memory model and its controller
package dwpr_pkg;
    localparam int BANKS      = 8;
    localparam int BA_W       = 3;
    localparam int ROW_W      = 4;
    localparam int COL_W      = 3;
    localparam int DQ_W       = 8;
    localparam int A10_POS    = 10;
    localparam int A12_POS    = 12;
    localparam int ADDR_W     = 14;
    localparam int CLK_MHZ    = 125;
    // times in nanoseconds, cycle counts derived (minimums round up)
    localparam int T_RP_NS    = 14;
    localparam int T_RFC_NS   = 160;
    localparam int T_WR_NS    = 15;
    localparam int T_REFI_NS  = 7800;
    localparam int T_RCD_NS   = 14;
    localparam int RP_CYC     = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int RFC_CYC    = (T_RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_CYC     = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_CYC    = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int REFI_CYC   = (T_REFI_NS * CLK_MHZ) / 1000;
    localparam int VREF_CYC   = 512;
    localparam int MAX_POSTED = 8;
    localparam int MAX_BURST  = 16;
    localparam int CNT_W      = 12;
    localparam int BL8_BEATS  = 8;
    localparam int BC4_BEATS  = 4;

    // command encodings {rasN, casN, weN} with csN low
    typedef enum logic [2:0] {
        DWPR_CMD_MRS = 3'h0,
        DWPR_CMD_REF = 3'h1,
        DWPR_CMD_PRE = 3'h2,
        DWPR_CMD_ACT = 3'h3,
        DWPR_CMD_WR  = 3'h4,
        DWPR_CMD_ZQ  = 3'h6,
        DWPR_CMD_NOP = 3'h7
    } dwpr_cmd_t;
endpackage

// ### dwpr_if.sv
// command and data pins joining the controller to the memory model
`timescale 1ns/100ps
interface dwpr_if;
    import dwpr_pkg::*;
    logic                cke;
    logic                csN;
    logic                rasN;
    logic                casN;
    logic                weN;
    logic [BA_W-1:0]     ba;
    logic [ADDR_W-1:0]   addr;
    logic [DQ_W-1:0]     dq;
    logic                dm;
    logic                dqValid;
    logic                vrefValid;
    logic                selfRefresh;

    modport ctrl (output cke, csN, rasN, casN, weN, ba, addr, dq, dm, dqValid, vrefValid,
                  input selfRefresh);
    modport mem  (input cke, csN, rasN, casN, weN, ba, addr, dq, dm, dqValid, vrefValid,
                  output selfRefresh);
endinterface

// ### dwpr_fifo.sv
// parameterised valid/ready fifo for write data beats
`timescale 1ns/100ps
module dwpr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0]   cnt;
    } dwpr_fifo_st_t;

    dwpr_fifo_st_t         s_reg;
    dwpr_fifo_st_t         s_next;
    logic [WIDTH-1:0]      mem [DEPTH];
    logic                  push;
    logic                  pop;

    // handshakes on both sides
    assign inReady  = (s_reg.cnt != (PW+1)'(DEPTH));
    assign outValid = (s_reg.cnt != '0);
    assign outData  = mem[s_reg.rp];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // pointer and fill count update
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    // state register and storage write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
        if (push) begin
            mem[s_reg.wp] <= inData;
        end
    end
endmodule

// ### dwpr_mem.sv
// command-level memory end: write, precharge, refresh and self refresh handling
// Notes on behaviour
// - write bursts into open row of chosen bank
// - A10 high on write auto-precharges afterwards
// - on-the-fly A12 picks four or eight beats
// - masked beats leave array contents unchanged
// - controller waits precharge time before activate
// - other-bank access allowed during auto precharge
// - precharge A10 high closes every bank
// - controller activates idle bank before access
// - precharge of idle bank does nothing
// - precharge timing restarts on latest precharge
// - refresh uses internal row counter only
// - controller refreshes every 7.8 or 3.9 us (controller uses REFI_CYC, 7.8 us only)
// - only nop or deselect during refresh period
// - at most eight refreshes postponed
// - postponements across self refresh total eight
// - at most 16 refreshes per two intervals
// - clock enable high for precharge, activate, refresh
// - precharge all before refresh when banks open
// - self refresh keeps contents without clock
// - wait 512 clocks after reference before write
// - refresh with clock enable falling enters self refresh
// - deselect or nop executes no new command
`timescale 1ns/100ps
module dwpr_mem #(
    parameter int  ROWS  = 16,
    parameter int  COLS  = 8,
    parameter bit  OTF   = 1'b1
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    dwpr_if.mem                         pins,
    input  wire logic [dwpr_pkg::BA_W-1:0]  rdBank,
    input  wire logic [dwpr_pkg::ROW_W-1:0] rdRow,
    input  wire logic [dwpr_pkg::COL_W-1:0] rdCol,
    output logic      [dwpr_pkg::DQ_W-1:0]  rdData,
    output logic      [dwpr_pkg::BANKS-1:0] bankOpen,
    output logic      [dwpr_pkg::ROW_W-1:0] refreshRow
);
    import dwpr_pkg::*;

    typedef struct packed {
        logic [BANKS-1:0]            open;
        logic [BANKS-1:0][ROW_W-1:0] row;
        logic [BANKS-1:0][CNT_W-1:0] preCnt;
        logic [BANKS-1:0]            autoPre;
        logic                        busy;
        logic [BA_W-1:0]             wBank;
        logic [COL_W-1:0]            wCol;
        logic [3:0]                  beatsLeft;
        logic [ROW_W-1:0]            refRow;
        logic                        selfRef;
        logic                        ckePrev;
        logic [DQ_W-1:0]             rdData;
    } dwpr_mem_st_t;

    dwpr_mem_st_t          s_reg;
    dwpr_mem_st_t          s_next;
    logic [DQ_W-1:0]       array [BANKS*ROWS*COLS];
    logic                  cmdTaken;
    dwpr_cmd_t             cmd;
    logic                  doWrite;
    logic [BA_W-1:0]       wrBankNow;

    // flat array index of a bank, row and column
    function automatic int arrIdx(input logic [BA_W-1:0] b, input logic [ROW_W-1:0] r,
                                  input logic [COL_W-1:0] c);
        return (int'(b) * ROWS + int'(r)) * COLS + int'(c);
    endfunction

    // command decode: deselect and nop run nothing new; refresh may drop clock enable
    assign cmdTaken  = !pins.csN && s_reg.ckePrev && !s_reg.selfRef
                       && (pins.cke || cmd == DWPR_CMD_REF);
    assign cmd       = dwpr_cmd_t'({pins.rasN, pins.casN, pins.weN});
    assign doWrite   = s_reg.busy && pins.dqValid && !pins.dm;
    assign wrBankNow = s_reg.wBank;

    // next-state logic for banks, bursts, refresh and self refresh
    always_comb begin
        s_next = s_reg;
        s_next.ckePrev = pins.cke;
        s_next.rdData  = array[arrIdx(rdBank, rdRow, rdCol)];
        // precharge timers run; bank closes when timer expires
        for (int b = 0; b < BANKS; b++) begin
            if (s_reg.preCnt[b] != '0) begin
                s_next.preCnt[b] = s_reg.preCnt[b] - 1'b1;
                if (s_reg.preCnt[b] == CNT_W'(1)) begin
                    s_next.open[b] = 1'b0;
                end
            end
        end
        // burst beats advance when data arrives, masked or not
        if (s_reg.busy && pins.dqValid) begin
            s_next.wCol      = s_reg.wCol + 1'b1;
            s_next.beatsLeft = s_reg.beatsLeft - 1'b1;
            if (s_reg.beatsLeft == 4'h1) begin
                s_next.busy = 1'b0;
                if (s_reg.autoPre[s_reg.wBank]) begin
                    s_next.autoPre[s_reg.wBank] = 1'b0;
                    s_next.preCnt[s_reg.wBank]  = CNT_W'(WR_CYC + RP_CYC);
                end
            end
        end
        // self refresh exit on clock enable return
        if (s_reg.selfRef && pins.cke) begin
            s_next.selfRef = 1'b0;
        end
        if (cmdTaken) begin
            case (cmd)
                DWPR_CMD_ACT: begin
                    s_next.open[pins.ba] = 1'b1;
                    s_next.row[pins.ba]  = pins.addr[ROW_W-1:0];
                end
                DWPR_CMD_WR: begin
                    if (s_reg.open[pins.ba] && s_reg.preCnt[pins.ba] == '0) begin
                        s_next.busy      = 1'b1;
                        s_next.wBank     = pins.ba;
                        s_next.wCol      = pins.addr[COL_W-1:0];
                        s_next.autoPre[pins.ba] = pins.addr[A10_POS];
                        s_next.beatsLeft = (OTF && !pins.addr[A12_POS]) ?
                                           4'(BC4_BEATS) : 4'(BL8_BEATS);
                    end
                end
                DWPR_CMD_PRE: begin
                    for (int b = 0; b < BANKS; b++) begin
                        // all banks on A10, else only the addressed one
                        if ((pins.addr[A10_POS] || BA_W'(b) == pins.ba) &&
                            s_reg.open[b] && !s_reg.autoPre[b]) begin
                            s_next.preCnt[b] = CNT_W'(RP_CYC);
                        end
                    end
                end
                DWPR_CMD_REF: begin
                    s_next.refRow = s_reg.refRow + 1'b1;
                    if (!pins.cke && s_reg.open == '0) begin
                        s_next.selfRef = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // state register and masked array write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
        if (doWrite) begin
            array[arrIdx(wrBankNow, s_reg.row[wrBankNow], s_reg.wCol)] <= pins.dq;
        end
    end

    // array contents are held with no dependence on clocking while in self refresh
    assign pins.selfRefresh = s_reg.selfRef;
    assign rdData     = s_reg.rdData;
    assign bankOpen   = s_reg.open;
    assign refreshRow = s_reg.refRow;
endmodule

// ### dwpr_ctrl.sv
// controller end: per-bank tracking, refresh scheduling and buffered write bursts
`timescale 1ns/100ps
module dwpr_ctrl #(
    parameter int REFI  = dwpr_pkg::REFI_CYC,
    parameter int DEPTH = 16
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    dwpr_if.ctrl                            pins,
    input  wire logic                       reqValid,
    output logic                            reqReady,
    input  wire logic [dwpr_pkg::BA_W-1:0]  reqBank,
    input  wire logic [dwpr_pkg::ROW_W-1:0] reqRow,
    input  wire logic [dwpr_pkg::COL_W-1:0] reqCol,
    input  wire logic                       reqChop,
    input  wire logic                       reqAutoPre,
    input  wire logic                       datValid,
    output logic                            datReady,
    input  wire logic [dwpr_pkg::DQ_W-1:0]  datByte,
    input  wire logic                       datMask,
    input  wire logic                       srReq,
    output logic                            srActive
);
    import dwpr_pkg::*;
    typedef enum logic [2:0] {IDLE, PRE, ACT, WR, DATA, REF, WAITT, SR} dwpr_st_t;
    typedef struct packed {
        dwpr_st_t                    st;
        logic [BANKS-1:0]            open;
        logic [BANKS-1:0][ROW_W-1:0] row;
        logic [CNT_W-1:0]            wait_;
        logic [CNT_W-1:0]            refiCnt;
        logic [3:0]                  posted;
        logic [3:0]                  beats;
        logic [9:0]                  vrefCnt;
        logic                        cke, csN, rasN, casN, weN, dqValid, dm, ack, srAct;
        logic [BA_W-1:0]             ba;
        logic [ADDR_W-1:0]           addr;
        logic [DQ_W-1:0]             dq;
    } dwpr_ctrl_st_t;

    dwpr_ctrl_st_t         s_reg;
    dwpr_ctrl_st_t         s_next;
    logic                  fValid;
    logic                  fPop;
    logic [DQ_W:0]         fData;

    dwpr_fifo #(.WIDTH(DQ_W+1), .DEPTH(DEPTH)) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (datValid),
        .inReady  (datReady),
        .inData   ({datMask, datByte}),
        .outValid (fValid),
        .outReady (fPop),
        .outData  (fData)
    );
    assign fPop = (s_reg.st == DATA) && (s_reg.beats != '0);

    // drive one command with clock enable high
    function automatic dwpr_ctrl_st_t issue(input dwpr_ctrl_st_t s, input dwpr_cmd_t c);
        dwpr_ctrl_st_t t;
        t = s;
        t.cke = 1'b1;
        t.csN = 1'b0;
        {t.rasN, t.casN, t.weN} = c;
        return t;
    endfunction

    // scheduler
    always_comb begin
        s_next = s_reg;
        s_next.csN = 1'b1;
        s_next.dqValid = 1'b0;
        s_next.ack = 1'b0;
        if (s_reg.wait_ != '0) begin
            s_next.wait_ = s_reg.wait_ - 1'b1;
        end
        if (s_reg.vrefCnt != '0) begin
            s_next.vrefCnt = s_reg.vrefCnt - 1'b1;
        end
        if (s_reg.refiCnt == '0) begin
            s_next.refiCnt = CNT_W'(REFI);
            if (s_reg.posted != 4'(MAX_POSTED + 1)) begin
                s_next.posted = s_reg.posted + 1'b1;
            end
        end else begin
            s_next.refiCnt = s_reg.refiCnt - 1'b1;
        end
        case (s_reg.st)
            IDLE: begin
                if (s_reg.wait_ != '0) begin
                end else if (s_reg.posted >= 4'(MAX_POSTED) || (srReq && !s_reg.srAct)) begin
                    if (s_reg.open != '0) begin
                        s_next = issue(s_next, DWPR_CMD_PRE);
                        s_next.addr = ADDR_W'(1) << A10_POS;
                        s_next.open = '0;
                        s_next.wait_ = CNT_W'(RP_CYC);
                    end else begin
                        s_next.st = REF;
                    end
                end else if (reqValid && s_reg.vrefCnt == '0) begin
                    if (s_reg.open[reqBank] && s_reg.row[reqBank] != reqRow) begin
                        s_next = issue(s_next, DWPR_CMD_PRE);
                        s_next.ba = reqBank;
                        s_next.addr = '0;
                        s_next.open[reqBank] = 1'b0;
                        s_next.wait_ = CNT_W'(RP_CYC);
                    end else if (!s_reg.open[reqBank]) begin
                        s_next = issue(s_next, DWPR_CMD_ACT);
                        s_next.ba = reqBank;
                        s_next.addr = ADDR_W'(reqRow);
                        s_next.open[reqBank] = 1'b1;
                        s_next.row[reqBank] = reqRow;
                        s_next.wait_ = CNT_W'(RCD_CYC);
                    end else begin
                        s_next = issue(s_next, DWPR_CMD_WR);
                        s_next.ba = reqBank;
                        s_next.addr = ADDR_W'(reqCol) | (ADDR_W'(reqAutoPre) << A10_POS)
                                    | (ADDR_W'(!reqChop) << A12_POS);
                        s_next.beats = reqChop ? 4'(BC4_BEATS) : 4'(BL8_BEATS);
                        s_next.ack = 1'b1;
                        s_next.st = DATA;
                        if (reqAutoPre) begin
                            s_next.open[reqBank] = 1'b0;
                        end
                    end
                end
            end
            DATA: begin
                if (s_reg.beats == '0) begin
                    s_next.st = IDLE;
                    s_next.wait_ = CNT_W'(WR_CYC + RP_CYC);
                end else if (fValid) begin
                    s_next.dqValid = 1'b1;
                    s_next.dq = fData[DQ_W-1:0];
                    s_next.dm = fData[DQ_W];
                    s_next.beats = s_reg.beats - 1'b1;
                end
            end
            REF: begin
                s_next = issue(s_next, DWPR_CMD_REF);
                if (srReq) begin
                    s_next.cke = 1'b0;
                    s_next.srAct = 1'b1;
                    s_next.st = SR;
                end else begin
                    s_next.posted = (s_next.posted != '0) ? s_next.posted - 1'b1 : '0;
                    s_next.wait_ = CNT_W'(RFC_CYC);
                    s_next.st = WAITT;
                end
            end
            WAITT: begin
                if (s_reg.wait_ == '0) begin
                    s_next.st = IDLE;
                end
            end
            SR: begin
                s_next.cke = 1'b0;
                s_next.posted = s_reg.posted;
                s_next.refiCnt = CNT_W'(REFI);
                if (!srReq) begin
                    s_next.cke = 1'b1;
                    s_next.srAct = 1'b0;
                    s_next.vrefCnt = 10'(VREF_CYC);
                    s_next.wait_ = CNT_W'(RFC_CYC);
                    s_next.st = WAITT;
                end
            end
            default: begin
                s_next.st = IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '{st: IDLE, cke: 1'b1, csN: 1'b1, rasN: 1'b1, casN: 1'b1,
                       weN: 1'b1, refiCnt: CNT_W'(REFI), default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins.cke       = s_reg.cke;
    assign pins.csN       = s_reg.csN;
    assign pins.rasN      = s_reg.rasN;
    assign pins.casN      = s_reg.casN;
    assign pins.weN       = s_reg.weN;
    assign pins.ba        = s_reg.ba;
    assign pins.addr      = s_reg.addr;
    assign pins.dq        = s_reg.dq;
    assign pins.dm        = s_reg.dm;
    assign pins.dqValid   = s_reg.dqValid;
    assign pins.vrefValid = !s_reg.srAct;
    assign reqReady       = s_reg.ack;
    assign srActive       = s_reg.srAct;
endmodule

// ### dwpr_assertions.sv
// concurrent checks on the pins between the controller and the memory end
`timescale 1ns/100ps
module dwpr_assertions #(
    parameter int REFI = 50
) (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        cke,
    input wire logic                        csN,
    input wire logic                        rasN,
    input wire logic                        casN,
    input wire logic                        weN,
    input wire logic [dwpr_pkg::BA_W-1:0]   ba,
    input wire logic [dwpr_pkg::ADDR_W-1:0] addr,
    input wire logic                        dqValid,
    input wire logic                        vrefValid,
    input wire logic                        selfRefresh
);
    import dwpr_pkg::*;
    typedef struct packed {
        logic [BANKS-1:0] open;
        logic [4:0]       quiet;
        logic [9:0]       hold;
        logic [3:0]       beat;
        logic [3:0]       blen;
        logic [15:0]      gap;
        logic             vref;
    } dwpr_chk_t;
    dwpr_chk_t  s;
    dwpr_chk_t  n;
    logic [2:0] cmd;
    logic       isRef, isPre, isAct, isWr;

    // command decode with chip select low
    assign cmd   = {rasN, casN, weN};
    assign isRef = !csN && cmd == DWPR_CMD_REF;
    assign isPre = !csN && cmd == DWPR_CMD_PRE;
    assign isAct = !csN && cmd == DWPR_CMD_ACT;
    assign isWr  = !csN && cmd == DWPR_CMD_WR;

    // open rows, refresh quiet time, reference hold-off, burst beats, refresh gap
    always_comb begin
        n = s;
        n.vref  = vrefValid;
        n.quiet = (s.quiet != 5'h0) ? s.quiet - 5'h1 : 5'h0;
        n.hold  = (s.hold != 10'h0) ? s.hold - 10'h1 : 10'h0;
        n.gap   = (isRef || selfRefresh) ? 16'h0 : s.gap + 16'h1;
        if (isRef) n.quiet = 5'(RFC_CYC - 1);
        if (vrefValid && !s.vref) n.hold = 10'(VREF_CYC - 2);
        if (dqValid) n.beat = s.beat + 4'h1;
        if (isWr) begin
            n.beat = 4'h0;
            n.blen = addr[A12_POS] ? 4'h8 : 4'h4;
        end
        if (isAct) n.open[ba] = 1'b1;
        if (isPre && addr[A10_POS]) n.open = '0;
        else if (isPre || (isWr && addr[A10_POS])) n.open[ba] = 1'b0;
    end

    // reference counts as valid out of reset
    always_ff @(posedge ref_clk) begin
        if (rst) s <= dwpr_chk_t'(1);
        else s <= n;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    refresh_quiet_a: assert property (s.quiet != 5'h0 |-> csN || cmd == DWPR_CMD_NOP)
        else $error("command issued inside refresh period");
    cke_cmd_a: assert property ((isPre || isAct || isRef) |-> $past(cke) && (cke || isRef))
        else $error("clock enable low around a command");
    precharge_wait_a: assert property (isPre |=> !isAct)
        else $error("activate too soon after precharge");
    vref_wait_a: assert property (isWr |-> s.hold == 10'h0)
        else $error("write too soon after reference valid");
    sr_entry_a: assert property (isRef && !cke && $past(cke) |=> selfRefresh)
        else $error("self refresh not entered");
    sr_hold_a: assert property (selfRefresh && !cke |=> selfRefresh)
        else $error("self refresh left while clock enable low");
    burst_len_a: assert property (dqValid |-> s.beat < s.blen)
        else $error("more data beats than burst length");
    refresh_gap_a: assert property (s.gap <= 16'(9 * REFI))
        else $error("refresh gap too long");
    write_open_a: assert property (isWr |-> s.open[ba])
        else $error("write to bank without open row");
    refresh_idle_a: assert property (isRef |-> s.open == '0)
        else $error("refresh with open banks");
endmodule

// ### dwpr_tb_top.sv
// self-checking bench joining controller and memory end through the pin interface
`timescale 1ns/100ps
module dwpr_tb_top;
    import dwpr_pkg::*;
    logic             ref_clk, rst, reqValid, reqReady, reqChop, reqAutoPre;
    logic             datValid, datReady, datMask, srReq, srActive;
    logic [BA_W-1:0]  reqBank, rdBank;
    logic [ROW_W-1:0] reqRow, rdRow, refreshRow;
    logic [COL_W-1:0] reqCol, rdCol;
    logic [DQ_W-1:0]  datByte, rdData;
    logic [BANKS-1:0] bankOpen;
    int               fails, compares, refs;
    dwpr_if           pins ();

    dwpr_ctrl #(.REFI(50), .DEPTH(16)) u_dwpr_ctrl (.ref_clk(ref_clk), .rst(rst),
        .pins(pins.ctrl), .reqValid(reqValid), .reqReady(reqReady), .reqBank(reqBank),
        .reqRow(reqRow), .reqCol(reqCol), .reqChop(reqChop), .reqAutoPre(reqAutoPre),
        .datValid(datValid), .datReady(datReady), .datByte(datByte), .datMask(datMask),
        .srReq(srReq), .srActive(srActive));
    dwpr_mem u_dwpr_mem (.ref_clk(ref_clk), .rst(rst), .pins(pins.mem), .rdBank(rdBank),
        .rdRow(rdRow), .rdCol(rdCol), .rdData(rdData), .bankOpen(bankOpen),
        .refreshRow(refreshRow));
    dwpr_assertions #(.REFI(50)) u_dwpr_assertions (.ref_clk(ref_clk), .rst(rst),
        .cke(pins.cke), .csN(pins.csN), .rasN(pins.rasN), .casN(pins.casN), .weN(pins.weN),
        .ba(pins.ba), .addr(pins.addr), .dqValid(pins.dqValid), .vrefValid(pins.vrefValid),
        .selfRefresh(pins.selfRefresh));

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // counts auto refresh commands on the pins
    always @(posedge ref_clk) begin
        if (!rst && pins.cke && !pins.csN && {pins.rasN, pins.casN, pins.weN} == DWPR_CMD_REF)
            refs <= refs + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // beats into the fifo, the one at index maskAt marked masked (none when maskAt is out of range)
    task automatic push_n(input int n, input logic [7:0] base, input int maskAt);
        for (int i = 0; i < n; i++) begin
            datValid <= 1'b1;
            datByte  <= base + 8'(i);
            datMask  <= (i == maskAt);
            do @(posedge ref_clk); while (datReady !== 1'b1);
        end
        datValid <= 1'b0;
    endtask

    task automatic request(input logic [2:0] b, input logic [3:0] r, input logic c, input logic ap);
        reqValid   <= 1'b1;
        reqBank    <= b;
        reqRow     <= r;
        reqChop    <= c;
        reqAutoPre <= ap;
        do @(posedge ref_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
    endtask

    task automatic readb(input logic [2:0] b, input logic [3:0] r, input int c, input logic [7:0] e);
        rdBank <= b;
        rdRow  <= r;
        rdCol  <= 3'(c);
        tick(2);
        check(16'(rdData), 16'(e));
    endtask

    task automatic s_fifo_fill();
        int n;
        n = 0;
        datValid <= 1'b1;
        datMask  <= 1'b0;
        datByte  <= 8'h40;
        repeat (20) begin
            @(posedge ref_clk);
            if (datReady === 1'b1) n++;
            datByte <= 8'h40 + 8'(n);
        end
        datValid <= 1'b0;
        check(16'(n), 16'h10);
        tick(1);
        request(3'h3, 4'h1, 1'b0, 1'b0);
        tick(1);
        request(3'h3, 4'h2, 1'b0, 1'b0);
        tick(20);
        readb(3'h3, 4'h1, 7, 8'h47);
        readb(3'h3, 4'h2, 0, 8'h48);
        check(16'(bankOpen[3]), 16'h1);
        check(16'(datReady), 16'h1);
    endtask

    task automatic s_write_bl8();
        push_n(8, 8'hA0, 99);
        tick(1);
        request(3'h1, 4'h3, 1'b0, 1'b0);
        tick(20);
        for (int c = 0; c < 8; c++) readb(3'h1, 4'h3, c, 8'hA0 + 8'(c));
        check(16'(bankOpen[1]), 16'h1);
    endtask

    task automatic s_chop_mask();
        push_n(8, 8'h10, 99);
        tick(1);
        request(3'h2, 4'h5, 1'b0, 1'b0);
        tick(1);
        push_n(4, 8'hC0, 1);
        tick(1);
        request(3'h2, 4'h5, 1'b1, 1'b1);
        tick(20);
        for (int c = 0; c < 8; c++)
            readb(3'h2, 4'h5, c, (c == 1 || c > 3) ? 8'h10 + 8'(c) : 8'hC0 + 8'(c));
        check(16'(bankOpen[2]), 16'h0);
    endtask

    task automatic s_refresh();
        logic [3:0] r0;
        int         c0;
        c0 = refs;
        // refreshes are postponed up to the limit first, so start at a landed one
        for (int i = 0; i < 500 && refs == c0; i++) tick(1);
        r0 = refreshRow;
        c0 = refs;
        tick(300);
        check(16'(refreshRow), 16'(4'(r0 + 4'(refs - c0))));
        check(16'(refs - c0 >= 5), 16'h1);
        check(16'(refs - c0 <= 3 * 16), 16'h1);
    endtask

    task automatic s_self_refresh();
        realtime t0;
        srReq <= 1'b1;
        for (int i = 0; i < 100 && srActive !== 1'b1; i++) tick(1);
        tick(2);
        check(16'({pins.selfRefresh, pins.cke}), 16'h2);
        tick(100);
        srReq <= 1'b0;
        for (int i = 0; i < 100 && srActive !== 1'b0; i++) tick(1);
        t0 = $realtime;
        push_n(8, 8'h60, 99);
        tick(1);
        request(3'h4, 4'h7, 1'b0, 1'b1);
        check(16'(($realtime - t0) >= 512 * 8), 16'h1);
        tick(20);
        readb(3'h1, 4'h3, 0, 8'hA0);
        readb(3'h4, 4'h7, 7, 8'h67);
    endtask

    task automatic print_verdict();
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {reqValid, reqChop, reqAutoPre, datValid, datMask, srReq} = '0;
        {reqBank, reqRow, reqCol, datByte, rdBank, rdRow, rdCol} = '0;
        fails = 0;
        compares = 0;
        refs = 0;
        tick(8);
        rst <= 1'b0;
        tick(1);
        s_fifo_fill();
        s_write_bl8();
        s_chop_mask();
        s_refresh();
        s_self_refresh();
        print_verdict();
    end

    // watchdog, far beyond the few thousand cycles the scenarios need
    initial begin
        #(8 * 60000);
        fails++;
        print_verdict();
    end
endmodule
